// *** verilog/bafe_regs.v ***
// Control, configuration and status registers of the pack front end, reached over I2C.
`timescale 1ns/1ns
`include "bafe_defines.vh"
module bafe_regs #(
   // Seven-bit bus address; the value is arbitrary.
   parameter [6:0] DEV_ADDR = 7'h2a
) (
   input wire core_clk,
   input wire resetn,
   input wire scl_in,
   input wire sda_in,
   output wire sda_out,
   output reg sda_oe,
   input wire wake_pin,
   input wire ext_overtemp,
   input wire int_overtemp,
   input wire discharge_short,
   input wire discharge_overcurrent,
   input wire charge_overcurrent,
   input wire heavy_load,
   output wire charge_switch_drive,
   output wire discharge_switch_drive,
   output wire load_monitor_on,
   output wire cell_balance_off,
   output wire regulator_on,
   output wire [6:0] analog_cell_select,
   output wire analog_ext_temp_sel,
   output wire analog_int_temp_sel,
   output wire discharge_oc_auto,
   output wire [1:0] discharge_oc_level,
   output wire short_auto,
   output wire [1:0] short_level,
   output wire [1:0] discharge_oc_delay,
   output wire charge_oc_auto,
   output wire [1:0] charge_oc_level,
   output wire long_short_delay,
   output wire [1:0] charge_oc_delay,
   output wire [6:0] charge_delay_divisor,
   output wire [6:0] discharge_delay_divisor,
   output wire auto_temp_scan_on,
   output wire thermistor_supply_on,
   output wire ext_thermal_shutdown_on,
   output wire int_thermal_shutdown_on,
   output reg force_por_pulse
);
   localparam ST_IDLE = 3'd0;
   localparam ST_DEV = 3'd1;
   localparam ST_RX = 3'd2;
   localparam ST_ACK = 3'd3;
   localparam ST_TX = 3'd4;
   localparam ST_TXACK = 3'd5;
   localparam ST_TXLD = 3'd6;

   wire [8:0] sync_v;
   reg scl_q;
   reg sda_q;
   reg wake_q;
   reg dis_oc_q;
   reg short_q;
   reg chg_oc_q;

   reg [2:0] state;
   reg [2:0] bit_cnt;
   reg [7:0] shift;
   reg [7:0] ptr;
   reg rw;
   reg ptr_phase;
   reg ack_on;
   reg wr_pulse;
   reg [7:0] wr_addr;
   reg [7:0] wr_data;

   reg user_flag_zero;
   reg user_flag_one;
   reg user_flag_two;
   reg user_flag_three;
   reg [3:0] analog_sel;
   reg sleep;
   reg load_monitor_enable;
   reg charge_switch_on;
   reg discharge_switch_on;
   reg [7:0] discharge_setup;
   reg [7:0] charge_setup;
   reg [7:0] feature_cfg;
   reg [2:0] unlock;
   reg external_overtemp_flag;
   reg internal_overtemp_flag;
   reg load_fail_flag;
   reg discharge_short_flag;
   reg discharge_overcurrent_flag;
   reg charge_overcurrent_flag;

   // Pin and analog condition inputs all cross into the core clock here.
   bafe_sync #(
      .WIDTH(9)
   ) u_sync (
      .core_clk(core_clk),
      .resetn(resetn),
      .async_in({heavy_load, charge_overcurrent, discharge_overcurrent, discharge_short,
         int_overtemp, ext_overtemp, wake_pin, sda_in, scl_in}),
      .sync_out(sync_v)
   );

   wire scl_s = sync_v[0];
   wire sda_s = sync_v[1];
   wire wake_s = sync_v[2];
   wire ext_ot_s = sync_v[3];
   wire int_ot_s = sync_v[4];
   wire short_s = sync_v[5];
   wire dis_oc_s = sync_v[6];
   wire chg_oc_s = sync_v[7];
   wire heavy_s = sync_v[8];

   wire scl_rise = scl_s & ~scl_q;
   wire scl_fall = ~scl_s & scl_q;
   wire bus_start = scl_s & scl_q & sda_q & ~sda_s;
   wire bus_stop = scl_s & scl_q & ~sda_q & sda_s;
   wire [7:0] rx_byte = {shift[6:0], sda_s};
   wire tx_load = scl_fall & ((state == ST_ACK && ack_on && rw) || state == ST_TXLD);
   wire wake_polarity = feature_cfg[`BAFE_BIT_WAKE_POL];
   wire wake_pin_disable = feature_cfg[`BAFE_BIT_WAKE_DISABLE];

   // Set has priority: an active condition holds the flag even during a read.
   function flag_next;
      input flag;
      input cond;
      input clr;
      begin
         flag_next = cond | (flag & ~clr);
      end
   endfunction

   function wr_hit;
      input pulse;
      input [7:0] addr;
      input [7:0] target;
      begin
         wr_hit = pulse && (addr == target);
      end
   endfunction

   wire wake_pin_state = ~(wake_s ^ wake_polarity);

   reg [7:0] rd_data;
   always @* begin
      case (ptr)
         `BAFE_ADDR_CONFIG_STATUS: rd_data = {2'b00, `BAFE_SINGLE_FRONTEND_VALUE,
            wake_pin_state, 4'h0};
         `BAFE_ADDR_FAULT_STATUS: rd_data = {2'b00, external_overtemp_flag,
            internal_overtemp_flag, load_fail_flag, discharge_short_flag,
            discharge_overcurrent_flag, charge_overcurrent_flag};
         `BAFE_ADDR_ANALOG_SEL: rd_data = {user_flag_one, user_flag_zero, 2'b00, analog_sel};
         `BAFE_ADDR_SWITCH_CTRL: rd_data = {sleep, load_monitor_enable, 4'h0,
            charge_switch_on, discharge_switch_on};
         `BAFE_ADDR_DISCHARGE_SETUP: rd_data = discharge_setup;
         `BAFE_ADDR_CHARGE_SETUP: rd_data = charge_setup;
         `BAFE_ADDR_FEATURE_CFG: rd_data = feature_cfg;
         `BAFE_ADDR_WRITE_UNLOCK: rd_data = {unlock, user_flag_three, user_flag_two, 3'h0};
         default: rd_data = 8'h00;
      endcase
   end

   always @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         scl_q <= 1'b1;
         sda_q <= 1'b1;
         wake_q <= 1'b0;
         dis_oc_q <= 1'b0;
         short_q <= 1'b0;
         chg_oc_q <= 1'b0;
      end else begin
         scl_q <= scl_s;
         sda_q <= sda_s;
         wake_q <= wake_s;
         dis_oc_q <= dis_oc_s;
         short_q <= short_s;
         chg_oc_q <= chg_oc_s;
      end
   end

   // Bus slave: address byte, pointer byte, then data bytes with auto increment.
   always @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         state <= ST_IDLE;
         bit_cnt <= 3'd0;
         shift <= 8'h00;
         ptr <= 8'h00;
         rw <= 1'b0;
         ptr_phase <= 1'b0;
         ack_on <= 1'b0;
         sda_oe <= 1'b0;
         wr_pulse <= 1'b0;
         wr_addr <= 8'h00;
         wr_data <= 8'h00;
      end else begin
         wr_pulse <= 1'b0;
         if (bus_start) begin
            state <= ST_DEV;
            bit_cnt <= 3'd0;
            ack_on <= 1'b0;
            sda_oe <= 1'b0;
         end else if (bus_stop) begin
            state <= ST_IDLE;
            ack_on <= 1'b0;
            sda_oe <= 1'b0;
         end else if (tx_load) begin
            shift <= rd_data;
            sda_oe <= ~rd_data[7];
            ptr <= ptr + 8'h01;
            bit_cnt <= 3'd0;
            ack_on <= 1'b0;
            state <= ST_TX;
         end else begin
            case (state)
               ST_DEV, ST_RX: begin
                  if (scl_rise) begin
                     shift <= rx_byte;
                     bit_cnt <= bit_cnt + 3'd1;
                     if (bit_cnt == 3'd7) begin
                        if (state == ST_DEV) begin
                           if (rx_byte[7:1] == DEV_ADDR) begin
                              state <= ST_ACK;
                              rw <= rx_byte[0];
                              ptr_phase <= ~rx_byte[0];
                           end else begin
                              state <= ST_IDLE;
                           end
                        end else begin
                           state <= ST_ACK;
                           if (ptr_phase) begin
                              ptr <= rx_byte;
                              ptr_phase <= 1'b0;
                           end else begin
                              wr_pulse <= 1'b1;
                              wr_addr <= ptr;
                              wr_data <= rx_byte;
                              ptr <= ptr + 8'h01;
                           end
                        end
                     end
                  end
               end
               ST_ACK: begin
                  if (scl_fall) begin
                     if (!ack_on) begin
                        ack_on <= 1'b1;
                        sda_oe <= 1'b1;
                     end else begin
                        ack_on <= 1'b0;
                        sda_oe <= 1'b0;
                        bit_cnt <= 3'd0;
                        state <= ST_RX;
                     end
                  end
               end
               ST_TX: begin
                  if (scl_rise) begin
                     bit_cnt <= bit_cnt + 3'd1;
                     if (bit_cnt == 3'd7)
                        state <= ST_TXACK;
                  end else if (scl_fall) begin
                     shift <= {shift[6:0], 1'b0};
                     sda_oe <= ~shift[6];
                  end
               end
               ST_TXACK: begin
                  if (scl_fall)
                     sda_oe <= 1'b0;
                  else if (scl_rise)
                     state <= sda_s ? ST_IDLE : ST_TXLD;
               end
               ST_TXLD: begin
                  sda_oe <= 1'b0;
               end
               default: begin
                  state <= ST_IDLE;
               end
            endcase
         end
      end
   end

   assign sda_out = 1'b0;

   wire wr_analog = wr_hit(wr_pulse, wr_addr, `BAFE_ADDR_ANALOG_SEL);
   wire wr_switch = wr_hit(wr_pulse, wr_addr, `BAFE_ADDR_SWITCH_CTRL);
   wire wr_unlock = wr_hit(wr_pulse, wr_addr, `BAFE_ADDR_WRITE_UNLOCK);
   wire wr_dis = wr_hit(wr_pulse, wr_addr, `BAFE_ADDR_DISCHARGE_SETUP) &
      unlock[`BAFE_BIT_DISCHARGE_UNLOCK - 5];
   wire wr_chg = wr_hit(wr_pulse, wr_addr, `BAFE_ADDR_CHARGE_SETUP) &
      unlock[`BAFE_BIT_CHARGE_UNLOCK - 5];
   wire wr_feat = wr_hit(wr_pulse, wr_addr, `BAFE_ADDR_FEATURE_CFG) &
      unlock[`BAFE_BIT_FEATURE_UNLOCK - 5];

   wire wake_evt = ~wake_pin_disable & (wake_polarity ? (wake_s & ~wake_q) : (~wake_s & wake_q));
   wire prot_trip = (dis_oc_s & ~dis_oc_q & ~discharge_setup[`BAFE_BIT_AUTO_OFF]) |
      (short_s & ~short_q & ~discharge_setup[`BAFE_BIT_SHORT_AUTO_OFF]) |
      (chg_oc_s & ~chg_oc_q & ~charge_setup[`BAFE_BIT_AUTO_OFF]);

   always @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         user_flag_zero <= 1'b0;
         user_flag_one <= 1'b0;
         user_flag_two <= 1'b0;
         user_flag_three <= 1'b0;
         analog_sel <= 4'h0;
         sleep <= 1'b0;
         load_monitor_enable <= 1'b0;
         charge_switch_on <= 1'b0;
         discharge_switch_on <= 1'b0;
         discharge_setup <= `BAFE_RESET_BYTE;
         charge_setup <= `BAFE_RESET_BYTE;
         feature_cfg <= `BAFE_RESET_BYTE;
         unlock <= 3'h0;
         force_por_pulse <= 1'b0;
      end else begin
         force_por_pulse <= 1'b0;
         if (wr_analog) begin
            user_flag_one <= wr_data[7];
            user_flag_zero <= wr_data[6];
            analog_sel <= wr_data[3:0];
         end
         if (wr_switch) begin
            sleep <= wr_data[`BAFE_BIT_SLEEP];
            load_monitor_enable <= wr_data[`BAFE_BIT_LOAD_MON];
            charge_switch_on <= wr_data[`BAFE_BIT_CHARGE_SW] & ~wr_data[`BAFE_BIT_SLEEP];
            discharge_switch_on <= wr_data[`BAFE_BIT_DISCHARGE_SW] &
               ~wr_data[`BAFE_BIT_SLEEP];
         end else if (wake_evt) begin
            sleep <= 1'b0;
         end
         if (prot_trip) begin
            charge_switch_on <= 1'b0;
            discharge_switch_on <= 1'b0;
         end
         if (wr_dis)
            discharge_setup <= {wr_data[7:5], wr_data[4:0]};
         if (wr_chg)
            charge_setup <= wr_data;
         if (wr_feat) begin
            feature_cfg <= {wr_data[7:3], 1'b0, wr_data[1:0]};
            force_por_pulse <= wr_data[`BAFE_BIT_FORCE_POR];
         end
         if (wr_unlock) begin
            unlock <= wr_data[7:5];
            user_flag_three <= wr_data[4];
            user_flag_two <= wr_data[3];
         end
      end
   end

   wire rd_fault = tx_load && (ptr == `BAFE_ADDR_FAULT_STATUS);
   wire dis_fault = dis_oc_s | short_s;
   wire load_fail_cond = load_monitor_enable & heavy_s & dis_fault;

   always @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         external_overtemp_flag <= 1'b0;
         internal_overtemp_flag <= 1'b0;
         load_fail_flag <= 1'b0;
         discharge_short_flag <= 1'b0;
         discharge_overcurrent_flag <= 1'b0;
         charge_overcurrent_flag <= 1'b0;
      end else begin
         external_overtemp_flag <= flag_next(external_overtemp_flag, ext_ot_s, rd_fault);
         internal_overtemp_flag <= flag_next(internal_overtemp_flag, int_ot_s, rd_fault);
         load_fail_flag <= flag_next(load_fail_flag, load_fail_cond, rd_fault);
         discharge_short_flag <= flag_next(discharge_short_flag, short_s, rd_fault);
         discharge_overcurrent_flag <= flag_next(discharge_overcurrent_flag, dis_oc_s,
            rd_fault);
         charge_overcurrent_flag <= flag_next(charge_overcurrent_flag, chg_oc_s, rd_fault);
      end
   end

   assign charge_switch_drive = charge_switch_on & ~sleep;
   assign discharge_switch_drive = discharge_switch_on & ~sleep;
   assign load_monitor_on = load_monitor_enable;
   assign cell_balance_off = sleep;
   assign regulator_on = ~sleep & ~feature_cfg[6];

   wire [7:0] sel_onehot = 8'h01 << analog_sel;
   assign analog_cell_select = sel_onehot[7:1];
   assign analog_ext_temp_sel = (analog_sel == `BAFE_ANALOG_EXT_TEMP);
   assign analog_int_temp_sel = (analog_sel == `BAFE_ANALOG_INT_TEMP);

   assign discharge_oc_auto = ~discharge_setup[`BAFE_BIT_AUTO_OFF];
   assign discharge_oc_level = discharge_setup[6:5];
   assign short_auto = ~discharge_setup[`BAFE_BIT_SHORT_AUTO_OFF];
   assign short_level = discharge_setup[3:2];
   assign discharge_oc_delay = discharge_setup[1:0];
   assign charge_oc_auto = ~charge_setup[`BAFE_BIT_AUTO_OFF];
   assign charge_oc_level = charge_setup[6:5];
   assign long_short_delay = charge_setup[`BAFE_BIT_LONG_SHORT];
   assign charge_oc_delay = charge_setup[1:0];
   assign charge_delay_divisor = charge_setup[`BAFE_BIT_CHARGE_DIV] ?
      `BAFE_CHARGE_DIVISOR : `BAFE_NO_DIVISOR;
   assign discharge_delay_divisor = charge_setup[`BAFE_BIT_DISCHARGE_DIV] ?
      `BAFE_DISCHARGE_DIVISOR : `BAFE_NO_DIVISOR;
   assign auto_temp_scan_on = ~feature_cfg[7];
   assign thermistor_supply_on = feature_cfg[5];
   assign ext_thermal_shutdown_on = ~feature_cfg[4];
   assign int_thermal_shutdown_on = ~feature_cfg[3];
endmodule

// *** verilog/bafe_defines.vh ***
// Register offsets, field positions, reset values and constants of the pack front end.
`ifndef BAFE_DEFINES_VH
`define BAFE_DEFINES_VH
`define BAFE_ADDR_CONFIG_STATUS 8'h00
`define BAFE_ADDR_FAULT_STATUS 8'h01
`define BAFE_ADDR_ANALOG_SEL 8'h03
`define BAFE_ADDR_SWITCH_CTRL 8'h04
`define BAFE_ADDR_DISCHARGE_SETUP 8'h05
`define BAFE_ADDR_CHARGE_SETUP 8'h06
`define BAFE_ADDR_FEATURE_CFG 8'h07
`define BAFE_ADDR_WRITE_UNLOCK 8'h08
`define BAFE_BIT_SINGLE_FRONTEND 5
`define BAFE_BIT_WAKE_STATE 4
`define BAFE_SINGLE_FRONTEND_VALUE 1'b1
`define BAFE_BIT_SLEEP 7
`define BAFE_BIT_LOAD_MON 6
`define BAFE_BIT_CHARGE_SW 1
`define BAFE_BIT_DISCHARGE_SW 0
`define BAFE_BIT_AUTO_OFF 7
`define BAFE_BIT_SHORT_AUTO_OFF 4
`define BAFE_BIT_LONG_SHORT 4
`define BAFE_BIT_CHARGE_DIV 3
`define BAFE_BIT_DISCHARGE_DIV 2
`define BAFE_BIT_FORCE_POR 2
`define BAFE_BIT_WAKE_DISABLE 1
`define BAFE_BIT_WAKE_POL 0
`define BAFE_BIT_FEATURE_UNLOCK 7
`define BAFE_BIT_CHARGE_UNLOCK 6
`define BAFE_BIT_DISCHARGE_UNLOCK 5
`define BAFE_ANALOG_EXT_TEMP 4'h8
`define BAFE_ANALOG_INT_TEMP 4'h9
`define BAFE_CHARGE_DIVISOR 7'h20
`define BAFE_DISCHARGE_DIVISOR 7'h40
`define BAFE_NO_DIVISOR 7'h01
`define BAFE_RESET_BYTE 8'h00
`endif

// *** verilog/bafe_sync.v ***
// Two-stage synchroniser for a group of asynchronous inputs.
`timescale 1ns/1ns
module bafe_sync #(
   parameter WIDTH = 9
) (
   input wire core_clk,
   input wire resetn,
   input wire [WIDTH-1:0] async_in,
   output reg [WIDTH-1:0] sync_out
);
   reg [WIDTH-1:0] meta;

   always @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         meta <= {WIDTH{1'b0}};
         sync_out <= {WIDTH{1'b0}};
      end else begin
         meta <= async_in;
         sync_out <= meta;
      end
   end
endmodule

// *** bench/bafe_regs_monitor.sv ***
// Port-level assertions for the pack front-end register block.
`timescale 1ns/1ns
`include "bafe_defines.vh"
module bafe_regs_monitor (
   input wire core_clk,
   input wire resetn,
   input wire charge_overcurrent,
   input wire discharge_overcurrent,
   input wire discharge_short,
   input wire charge_switch_drive,
   input wire discharge_switch_drive,
   input wire cell_balance_off,
   input wire regulator_on,
   input wire [6:0] analog_cell_select,
   input wire analog_ext_temp_sel,
   input wire analog_int_temp_sel,
   input wire discharge_oc_auto,
   input wire short_auto,
   input wire charge_oc_auto,
   input wire [6:0] charge_delay_divisor,
   input wire [6:0] discharge_delay_divisor
);
   default clocking mon_cb @(posedge core_clk);
   endclocking
   default disable iff (!resetn);
   // Both switch bits drop a few cycles after a synchronised trip.
   sequence trip_off;
      ##[1:6] (!charge_switch_drive && !discharge_switch_drive);
   endsequence
   AST_SLEEP_SW_OFF: assert property (
      cell_balance_off |-> !charge_switch_drive && !discharge_switch_drive)
      else $error("switch driven while asleep");
   AST_SLEEP_REG_OFF: assert property (
      cell_balance_off |-> !regulator_on)
      else $error("regulator on while asleep");
   AST_ANALOG_ONEHOT: assert property (
      $onehot0({analog_int_temp_sel, analog_ext_temp_sel, analog_cell_select}))
      else $error("analog select not one-hot");
   AST_CHARGE_DIV: assert property (
      charge_delay_divisor == `BAFE_CHARGE_DIVISOR || charge_delay_divisor == `BAFE_NO_DIVISOR)
      else $error("charge divisor illegal");
   AST_DISCHARGE_DIV: assert property (
      discharge_delay_divisor == `BAFE_DISCHARGE_DIVISOR
      || discharge_delay_divisor == `BAFE_NO_DIVISOR)
      else $error("discharge divisor illegal");
   AST_DOC_TRIP: assert property (
      $rose(discharge_overcurrent) && discharge_oc_auto |-> trip_off)
      else $error("overcurrent did not drop switches");
   AST_SHORT_TRIP: assert property (
      $rose(discharge_short) && short_auto |-> trip_off)
      else $error("short did not drop switches");
   AST_COC_TRIP: assert property (
      $rose(charge_overcurrent) && charge_oc_auto |-> trip_off)
      else $error("charge overcurrent did not drop switches");
endmodule
bind bafe_regs bafe_regs_monitor i_bafe_regs_monitor (.*);

// *** bench/bafe_i2c_host.sv ***
// Behavioural I2C host that reaches the front-end registers.
`timescale 1ns/1ns
module bafe_i2c_host #(
   parameter [6:0] DEV = 7'h2a
) (
   input wire core_clk,
   input wire sda,
   output reg scl,
   output reg host_oe,
   output reg nack_seen
);
   initial begin
      scl = 1'b1;
      host_oe = 1'b0;
      nack_seen = 1'b0;
   end
   // A quarter of the 160 ns bus period.
   task q;
      repeat (5) @(negedge core_clk);
   endtask
   task bit_out(input b);
      begin
         scl = 1'b0;
         q;
         host_oe = !b;
         q;
         scl = 1'b1;
         q;
         q;
      end
   endtask
   task bit_in(output b);
      begin
         scl = 1'b0;
         q;
         host_oe = 1'b0;
         q;
         scl = 1'b1;
         q;
         b = sda;
         q;
      end
   endtask
   task start;
      begin
         host_oe = 1'b1;
         q;
         q;
      end
   endtask
   task stop;
      begin
         scl = 1'b0;
         q;
         host_oe = 1'b1;
         q;
         scl = 1'b1;
         q;
         host_oe = 1'b0;
         q;
      end
   endtask
   task byte_out(input [7:0] d);
      integer i;
      reg a;
      begin
         for (i = 7; i >= 0; i = i - 1)
            bit_out(d[i]);
         bit_in(a);
         if (a)
            nack_seen = 1'b1;
      end
   endtask
   task write_reg(input [7:0] a, input [7:0] d);
      begin
         start;
         byte_out({DEV, 1'b0});
         byte_out(a);
         byte_out(d);
         stop;
      end
   endtask
   task read_reg(input [7:0] a, output [7:0] d);
      integer i;
      begin
         start;
         byte_out({DEV, 1'b0});
         byte_out(a);
         bit_out(1'b1);
         start;
         byte_out({DEV, 1'b1});
         for (i = 7; i >= 0; i = i - 1)
            bit_in(d[i]);
         bit_out(1'b1);
         stop;
      end
   endtask
endmodule

// *** bench/testbench.sv ***
// Self-checking bench for the pack front-end register block.
`timescale 1ns/1ns
`include "bafe_defines.vh"
module testbench;
   reg core_clk;
   reg resetn;
   reg wake_pin;
   reg [5:0] cond;
   reg [7:0] rd, d, c, f, u, e;
   reg h;
   integer seed, errors, total_checks, k, por_cnt;
   wire sdo, por, atso, xtsd, itsd, lsd;
   wire [1:0] dlev, slev, ddly, clev, cdly;
   wire scl, host_oe, nack_seen, sda_oe, csw, dsw, lmon, cbo, rego, ext_sel, int_sel;
   wire doc_auto, sc_auto, coc_auto, tsup;
   wire [6:0] cells, cdiv, ddiv;
   wire sda = !(sda_oe | host_oe);
   bafe_i2c_host #(.DEV(7'h2a)) i_bafe_i2c_host (.core_clk(core_clk), .sda(sda), .scl(scl),
      .host_oe(host_oe), .nack_seen(nack_seen));
   bafe_regs #(.DEV_ADDR(7'h2a)) i_bafe_regs (.core_clk(core_clk), .resetn(resetn),
      .scl_in(scl), .sda_in(sda), .sda_out(sdo), .sda_oe(sda_oe), .wake_pin(wake_pin),
      .ext_overtemp(cond[5]), .int_overtemp(cond[4]), .heavy_load(cond[3]),
      .discharge_short(cond[2]), .discharge_overcurrent(cond[1]), .charge_overcurrent(cond[0]),
      .charge_switch_drive(csw), .discharge_switch_drive(dsw), .load_monitor_on(lmon),
      .cell_balance_off(cbo), .regulator_on(rego), .analog_cell_select(cells),
      .analog_ext_temp_sel(ext_sel), .analog_int_temp_sel(int_sel),
      .discharge_oc_auto(doc_auto), .discharge_oc_level(dlev), .short_auto(sc_auto),
      .short_level(slev), .discharge_oc_delay(ddly), .charge_oc_auto(coc_auto),
      .charge_oc_level(clev), .long_short_delay(lsd), .charge_oc_delay(cdly),
      .charge_delay_divisor(cdiv), .discharge_delay_divisor(ddiv), .auto_temp_scan_on(atso),
      .thermistor_supply_on(tsup), .ext_thermal_shutdown_on(xtsd),
      .int_thermal_shutdown_on(itsd), .force_por_pulse(por));
   initial begin
      core_clk = 1'b0;
      forever #4 core_clk = ~core_clk;
   end
   // Counts the one-cycle restart pulses so a short pulse cannot be missed.
   always @(posedge core_clk)
      if (por === 1'b1)
         por_cnt <= por_cnt + 1;
   function [7:0] cfg(input w, input p);
      cfg = {2'b00, `BAFE_SINGLE_FRONTEND_VALUE, ~(w ^ p), 4'h0};
   endfunction
   function [8:0] ao(input [3:0] s);
      ao = (s == 0 || s > 9) ? 9'h0 : (s == 8) ? 9'h080 : (s == 9) ? 9'h100 : 9'h1 << (s - 1);
   endfunction
   task chk(input [15:0] got, input [15:0] exp);
      begin
         total_checks = total_checks + 1;
         if (got !== exp) begin
            errors = errors + 1;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
         end
      end
   endtask
   task wrc(input [7:0] a, input [7:0] v, input [7:0] x);
      begin
         i_bafe_i2c_host.write_reg(a, v);
         i_bafe_i2c_host.read_reg(a, rd);
         chk(rd, x);
      end
   endtask
   task report_and_stop;
      begin
         $display("checks %0d errors %0d", total_checks, errors);
         if (errors == 0 && total_checks > 0)
            $display("ALL CHECKS OK");
         else
            $display("CHECKS NOT OK");
         $finish;
      end
   endtask
   initial begin
      #760000;
      errors = errors + 1;
      report_and_stop;
   end
   initial begin
      seed = 32'h979e;
      errors = 0;
      total_checks = 0;
      por_cnt = 0;
      resetn = 1'b0;
      wake_pin = 1'b0;
      cond = 6'h00;
      repeat (12) @(negedge core_clk);
      resetn = 1'b1;
      repeat (3) @(negedge core_clk);
      i_bafe_i2c_host.read_reg(8'h00, rd);
      chk(rd, cfg(1'b0, 1'b0));
      for (k = 1; k < 10; k = k + 1) begin
         if (k != 2) begin
            i_bafe_i2c_host.read_reg((k == 9) ? 8'h0b : k, rd);
            chk(rd, 8'h00);
         end
      end
      wrc(8'h05, 8'h9c, 8'h00);
      u = ($random(seed) & 8'h18) | 8'he0;
      wrc(8'h08, u, u);
      for (k = 0; k < 2; k = k + 1) begin
         d = $random(seed) & 8'hdf;
         c = $random(seed) & 8'hdf;
         f = $random(seed) & 8'hf9;
         wrc(8'h05, d, d);
         wrc(8'h06, c, c);
         wrc(8'h07, f, f);
         chk({doc_auto, sc_auto, coc_auto, tsup, rego}, {!d[7], !d[4], !c[7], f[5], !f[6]});
         chk({cdiv, ddiv}, {c[3] ? 7'h20 : 7'h01, c[2] ? 7'h40 : 7'h01});
         chk({dlev, slev, ddly}, {d[6:5], d[3:2], d[1:0]});
         chk({clev, lsd, cdly}, {c[6:5], c[4], c[1:0]});
         chk({atso, xtsd, itsd}, {!f[7], !f[4], !f[3]});
      end
      wrc(8'h07, f | 8'h04, f);
      chk(por_cnt, 1);
      for (k = 0; k < 16; k = k + 1) begin
         u = ($random(seed) & 8'hc0) | k;
         i_bafe_i2c_host.write_reg(8'h03, u);
         chk({int_sel, ext_sel, cells}, ao(k));
      end
      wrc(8'h04, 8'h43, 8'h43);
      chk({csw, dsw, lmon}, 3'b111);
      wrc(8'h04, 8'hc3, 8'hc0);
      chk({csw, dsw, cbo, rego}, 4'b0010);
      i_bafe_i2c_host.read_reg(8'h03, rd);
      chk(rd, u);
      wrc(8'h04, 8'h00, 8'h00);
      for (k = 0; k < 2; k = k + 1) begin
         wake_pin = !k[0];
         wrc(8'h07, k, k);
         wrc(8'h04, 8'h80, 8'h80);
         i_bafe_i2c_host.read_reg(8'h00, rd);
         chk(rd, cfg(!k[0], k[0]));
         wake_pin = k[0];
         repeat (10) @(negedge core_clk);
         i_bafe_i2c_host.read_reg(8'h04, rd);
         chk(rd, 8'h00);
         i_bafe_i2c_host.read_reg(8'h00, rd);
         chk(rd, cfg(k[0], k[0]));
      end
      wrc(8'h05, 8'h00, 8'h00);
      wrc(8'h06, 8'h00, 8'h00);
      for (k = 0; k < 6; k = k + 1) begin
         if (k != 3) begin
            wrc(8'h04, 8'h43, 8'h43);
            h = $random(seed);
            cond = (6'h01 << k) | {2'b00, h, 3'b000};
            repeat (10) @(negedge core_clk);
            e = (8'h01 << k) | ((h && (k == 1 || k == 2)) ? 8'h08 : 8'h00);
            i_bafe_i2c_host.read_reg(8'h04, rd);
            if (k < 3)
               chk(rd, 8'h40);
            i_bafe_i2c_host.read_reg(8'h01, rd);
            chk(rd, e);
            cond = 6'h00;
            repeat (10) @(negedge core_clk);
            i_bafe_i2c_host.read_reg(8'h01, rd);
            chk(rd, e);
            i_bafe_i2c_host.read_reg(8'h01, rd);
            chk(rd, 8'h00);
         end
      end
      chk({nack_seen, sdo}, 2'b00);
      report_and_stop;
   end
endmodule
